// >>> design/ecdr_regs.svh
// register offsets, field positions, reset values and timing counts of the divided clock block
//
// Notes on behaviour
// - clock mode code 16 routes the external clock through the divider to the sample clock
// - divider setting is even, at most 8190; external clock is divided by it
// - band register takes 64 for the slow band and 128 for the fast band
// - 8-bit boards: boundary 50.0 MHz for 1-2 channels, 25.0 for 4, 12.5 for 8
// - 12/14/16-bit boards: boundary 50.0, 25.0, 12.5, 6.0 MHz for 1, 2, 4, 8 channels
// - slow band tolerates gaps; the first sample after a gap is marked invalid
// - divided external edges drive the sample clock directly, no re-synthesis
// - termination bit 1 enables 50 Ohm only while the connector is an input
`ifndef ECDR_REGS_SVH
`define ECDR_REGS_SVH

`define ECDR_OFF_DIV       16'h4e48
`define ECDR_OFF_TERM      16'h4e98
`define ECDR_OFF_MODE      16'h4ee8
`define ECDR_OFF_BAND      16'h4f00
`define ECDR_OFF_CMD       16'h4f04
`define ECDR_OFF_STAT      16'h4f08
`define ECDR_OFF_LIMIT     16'h4f0c

`define ECDR_MODE_DIVIDED  32'h00000010
`define ECDR_BAND_SLOW     8'h40
`define ECDR_BAND_FAST     8'h80
`define ECDR_DIV_MAX       8190
`define ECDR_DIV_W         13
`define ECDR_DIV_RST       13'h0002
`define ECDR_MODE_RST      32'h00000000

`define ECDR_CMD_START     0
`define ECDR_CMD_STOP      1
`define ECDR_STAT_RUN      0
`define ECDR_STAT_PRESENT  1
`define ECDR_STAT_ERR_DIV  2
`define ECDR_STAT_ERR_BAND 3
`define ECDR_STAT_ERR_STRT 4
`define ECDR_STAT_GAP      5
`define ECDR_STAT_TERM     6

`define ECDR_LIM_50M0      32'h0000c350
`define ECDR_LIM_25M0      32'h000061a8
`define ECDR_LIM_12M5      32'h000030d4
`define ECDR_LIM_6M0       32'h00001770

`define ECDR_SYS_MHZ       20
`define ECDR_GAP_NS        10000
`define ECDR_GAP_CYC       ((`ECDR_GAP_NS * `ECDR_SYS_MHZ) / 1000)

`endif

// >>> design/ecdr_pkg.sv
// types shared by the divided clock block
`default_nettype none
`include "ecdr_regs.svh"
package ecdr_pkg;
	typedef enum logic [1:0] {
		ECDR_IDLE  = 2'b00,
		ECDR_ARMED = 2'b01,
		ECDR_RUN   = 2'b10
	} ecdr_run_t;

	typedef struct packed {
		logic [`ECDR_DIV_W-1:0] cnt;
		logic                   dclk;
		logic                   tick;
	} ecdr_div_st_t;

	typedef struct packed {
		logic [31:0]            mode;
		logic [`ECDR_DIV_W-1:0] div;
		logic [7:0]             band;
		logic                   term;
		ecdr_run_t              run;
		logic                   ext_prev;
		logic [15:0]            gap_cnt;
		logic                   present;
		logic                   skip;
		logic                   err_div;
		logic                   err_band;
		logic                   err_start;
		logic                   gap_seen;
		logic [31:0]            rdata;
		logic                   sclk;
		logic                   tick;
		logic                   valid;
		logic                   term_en;
		logic                   fast_sel;
		logic                   div_mode;
	} ecdr_top_st_t;
endpackage : ecdr_pkg
`default_nettype wire

// >>> design/ecdr_div_if.sv
// signals between the control logic and the edge divider
`default_nettype none
`include "ecdr_regs.svh"
interface ecdr_div_if;
	logic [`ECDR_DIV_W-1:0] div_val;
	logic                   enable;
	logic                   ext_edge;
	logic                   div_clk;
	logic                   div_tick;

	modport ctl (output div_val, output enable, output ext_edge,
		input div_clk, input div_tick);
	modport dvd (input div_val, input enable, input ext_edge,
		output div_clk, output div_tick);
endinterface : ecdr_div_if
`default_nettype wire

// >>> design/ecdr_divider.sv
// edge counting divider that turns external clock edges into the divided sample clock
`default_nettype none
`include "ecdr_regs.svh"
module ecdr_divider (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic nrst,
	// control side
	ecdr_div_if.dvd   dif
);
	import ecdr_pkg::*;

	ecdr_div_st_t st_r;
	ecdr_div_st_t st_nxt;
	logic [`ECDR_DIV_W-1:0] half;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		// half period in external edges; a smaller new setting wraps on the next edge
		half = {1'b0, dif.div_val[`ECDR_DIV_W-1:1]};
		if (!dif.enable) begin
			st_nxt.cnt = '0;
			st_nxt.dclk = 1'b0;
		end else if (dif.ext_edge) begin
			if (`ECDR_DIV_W'(st_r.cnt + `ECDR_DIV_W'(1)) >= half) begin
				st_nxt.cnt = '0;
				st_nxt.dclk = ~st_r.dclk;
				st_nxt.tick = ~st_r.dclk;
			end else begin
				st_nxt.cnt = `ECDR_DIV_W'(st_r.cnt + `ECDR_DIV_W'(1));
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dif.div_clk = st_r.dclk;
	assign dif.div_tick = st_r.tick;
endmodule : ecdr_divider
`default_nettype wire

// >>> design/ecdr_top.sv
// divided external sample clock: registers, run control, gap watch and band checks
//
// Chosen here: strobed register access.
`default_nettype none
`include "ecdr_regs.svh"
module ecdr_top #(
	parameter int unsigned DIV_MAX = `ECDR_DIV_MAX,
	parameter int unsigned GAP_CYC = `ECDR_GAP_CYC
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// external clock connector and board setup
	input  wire logic        ext_clk_in,
	input  wire logic        clk_out_drive,
	input  wire logic        res_8bit,
	input  wire logic [3:0]  chan_per_module,
	// sample clock side
	output logic             sample_clk,
	output logic             sample_tick,
	output logic             sample_valid,
	// front end controls
	output logic             term_en,
	output logic             band_fast_sel,
	output logic             divided_mode_on
);
	import ecdr_pkg::*;

	ecdr_top_st_t st_r;
	ecdr_top_st_t st_nxt;
	ecdr_div_if   dif ();

	logic        ext_edge;
	logic        wr_div;
	logic        wr_term;
	logic        wr_mode;
	logic        wr_band;
	logic        wr_cmd;
	logic        wr_stat;
	logic        start_cmd;
	logic        stop_cmd;
	logic        in_div_mode;
	logic        present_nxt;
	logic        gap_event;
	logic        running;
	logic [31:0] limit_khz;

	// band boundary in kHz for the present resolution and channels per module
	function automatic logic [31:0] band_limit(input logic r8, input logic [3:0] ch);
		logic [31:0] lim;
		lim = 32'h00000000;
		if (r8) begin
			if (ch == 4'h1 || ch == 4'h2) begin
				lim = `ECDR_LIM_50M0;
			end else if (ch == 4'h4) begin
				lim = `ECDR_LIM_25M0;
			end else if (ch == 4'h8) begin
				lim = `ECDR_LIM_12M5;
			end
		end else begin
			if (ch == 4'h1) begin
				lim = `ECDR_LIM_50M0;
			end else if (ch == 4'h2) begin
				lim = `ECDR_LIM_25M0;
			end else if (ch == 4'h4) begin
				lim = `ECDR_LIM_12M5;
			end else if (ch == 4'h8) begin
				lim = `ECDR_LIM_6M0;
			end
		end
		return lim;
	endfunction : band_limit

	// even, nonzero and not above the limit
	function automatic logic div_ok(input logic [31:0] v, input int unsigned vmax);
		return (v[0] == 1'b0) && (v != 32'h00000000) && (v <= 32'(vmax));
	endfunction : div_ok

	// write decode
	always_comb begin
		wr_div = 1'b0;
		wr_term = 1'b0;
		wr_mode = 1'b0;
		wr_band = 1'b0;
		wr_cmd = 1'b0;
		wr_stat = 1'b0;
		if (reg_wr) begin
			if (reg_addr == `ECDR_OFF_DIV) begin
				wr_div = 1'b1;
			end else if (reg_addr == `ECDR_OFF_TERM) begin
				wr_term = 1'b1;
			end else if (reg_addr == `ECDR_OFF_MODE) begin
				wr_mode = 1'b1;
			end else if (reg_addr == `ECDR_OFF_BAND) begin
				wr_band = 1'b1;
			end else if (reg_addr == `ECDR_OFF_CMD) begin
				wr_cmd = 1'b1;
			end else if (reg_addr == `ECDR_OFF_STAT) begin
				wr_stat = 1'b1;
			end
		end
	end

	// inputs are synchronous, so a previous-value flop is enough for the edge
	assign ext_edge = ext_clk_in & ~st_r.ext_prev;
	assign start_cmd = wr_cmd & reg_wdata[`ECDR_CMD_START];
	assign stop_cmd = wr_cmd & reg_wdata[`ECDR_CMD_STOP];
	assign in_div_mode = (st_r.mode == `ECDR_MODE_DIVIDED);
	assign running = (st_r.run == ECDR_RUN);
	assign limit_khz = band_limit(res_8bit, chan_per_module);

	// the clock counts as present while edges keep arriving within the gap window
	assign present_nxt = ext_edge || (st_r.present && (st_r.gap_cnt < 16'(GAP_CYC - 1)));
	assign gap_event = st_r.present & ~present_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.ext_prev = ext_clk_in;
		st_nxt.rdata = 32'h00000000;

		// register writes
		if (wr_div) begin
			if (div_ok(reg_wdata, DIV_MAX)) begin
				st_nxt.div = reg_wdata[`ECDR_DIV_W-1:0];
			end else begin
				st_nxt.err_div = 1'b1;
			end
		end
		if (wr_term) begin
			st_nxt.term = reg_wdata[0];
		end
		if (wr_mode) begin
			st_nxt.mode = reg_wdata;
		end
		if (wr_band) begin
			if (reg_wdata == {24'h000000, `ECDR_BAND_SLOW} ||
				reg_wdata == {24'h000000, `ECDR_BAND_FAST}) begin
				st_nxt.band = reg_wdata[7:0];
			end else begin
				st_nxt.err_band = 1'b1;
			end
		end

		// gap watch
		if (ext_edge) begin
			st_nxt.gap_cnt = 16'h0000;
		end else if (st_r.gap_cnt != 16'hffff) begin
			st_nxt.gap_cnt = 16'(st_r.gap_cnt + 16'h0001);
		end
		st_nxt.present = present_nxt;

		// sticky flags: clearing by writing one, a fresh event in the same cycle wins
		if (wr_stat) begin
			if (reg_wdata[`ECDR_STAT_ERR_DIV] && !(wr_div && !div_ok(reg_wdata, DIV_MAX))) begin
				st_nxt.err_div = 1'b0;
			end
			if (reg_wdata[`ECDR_STAT_ERR_BAND]) begin
				st_nxt.err_band = 1'b0;
			end
			if (reg_wdata[`ECDR_STAT_ERR_STRT]) begin
				st_nxt.err_start = 1'b0;
			end
			if (reg_wdata[`ECDR_STAT_GAP]) begin
				st_nxt.gap_seen = 1'b0;
			end
		end

		// run control
		case (st_r.run)
			ECDR_IDLE: begin
				if (start_cmd && in_div_mode) begin
					if (st_r.band == `ECDR_BAND_FAST && !st_r.present) begin
						// a fast band start without clock is held until the first edge
						st_nxt.err_start = 1'b1;
						st_nxt.run = ECDR_ARMED;
					end else begin
						st_nxt.run = ECDR_RUN;
					end
					st_nxt.skip = 1'b0;
				end else if (start_cmd) begin
					st_nxt.err_start = 1'b1;
				end
			end
			ECDR_ARMED: begin
				if (stop_cmd || !in_div_mode) begin
					st_nxt.run = ECDR_IDLE;
				end else if (ext_edge) begin
					st_nxt.run = ECDR_RUN;
				end
			end
			ECDR_RUN: begin
				if (stop_cmd || !in_div_mode) begin
					st_nxt.run = ECDR_IDLE;
				end
			end
			default: begin
				st_nxt.run = ECDR_IDLE;
			end
		endcase

		// the sample after a gap is not trusted, in either band
		if (running && dif.div_tick) begin
			st_nxt.skip = 1'b0;
		end
		if (running && gap_event) begin
			st_nxt.skip = 1'b1;
			st_nxt.gap_seen = 1'b1;
		end

		// registered outputs
		st_nxt.sclk = dif.div_clk & running;
		st_nxt.tick = dif.div_tick & running;
		st_nxt.valid = dif.div_tick & running & ~st_r.skip;
		st_nxt.term_en = st_r.term & ~clk_out_drive;
		st_nxt.fast_sel = (st_r.band == `ECDR_BAND_FAST);
		st_nxt.div_mode = in_div_mode;

		// read data stands only in the cycle after the strobe
		if (reg_rd) begin
			if (reg_addr == `ECDR_OFF_DIV) begin
				st_nxt.rdata = {{(32 - `ECDR_DIV_W){1'b0}}, st_r.div};
			end else if (reg_addr == `ECDR_OFF_TERM) begin
				st_nxt.rdata = {31'h00000000, st_r.term};
			end else if (reg_addr == `ECDR_OFF_MODE) begin
				st_nxt.rdata = st_r.mode;
			end else if (reg_addr == `ECDR_OFF_BAND) begin
				st_nxt.rdata = {24'h000000, st_r.band};
			end else if (reg_addr == `ECDR_OFF_STAT) begin
				st_nxt.rdata = {25'h0000000, st_r.term_en, st_r.gap_seen, st_r.err_start,
					st_r.err_band, st_r.err_div, st_r.present, running};
			end else if (reg_addr == `ECDR_OFF_LIMIT) begin
				st_nxt.rdata = limit_khz;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.mode <= `ECDR_MODE_RST;
			st_r.div <= `ECDR_DIV_RST;
			st_r.band <= `ECDR_BAND_SLOW;
			st_r.run <= ECDR_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// the divider only counts while running in divided mode
	assign dif.div_val = st_r.div;
	assign dif.enable = running & in_div_mode;
	assign dif.ext_edge = ext_edge;

	ecdr_divider u_div (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.dif     (dif)
	);

	assign reg_rdata = st_r.rdata;
	assign sample_clk = st_r.sclk;
	assign sample_tick = st_r.tick;
	assign sample_valid = st_r.valid;
	assign term_en = st_r.term_en;
	assign band_fast_sel = st_r.fast_sel;
	assign divided_mode_on = st_r.div_mode;
endmodule : ecdr_top
`default_nettype wire

// >>> bench/ecdr_clk_gen.sv
// external clock generator model driving the clock connector
`default_nettype none
module ecdr_clk_gen (
	// timing reference
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// generator control
	input  wire logic       run,
	input  wire logic [3:0] half,
	// connector
	output logic            ext_clk
);
	logic [3:0] cnt;
	// steady square wave without steps while on; parked low when off so gaps are real
	// a fixed half period keeps the divided clock below every band boundary while running
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst || !run) begin
			cnt <= 4'h0;
			ext_clk <= 1'b0;
		end else if (cnt == half - 4'h1) begin
			cnt <= 4'h0;
			ext_clk <= ~ext_clk;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : ecdr_clk_gen
`default_nettype wire

// >>> bench/ecdr_top_checker.sv
// concurrent checks on the ports of the divided clock block
`default_nettype none
`include "ecdr_regs.svh"
module ecdr_top_checker #(
	parameter int unsigned DIV_MAX = `ECDR_DIV_MAX,
	parameter int unsigned GAP_CYC = `ECDR_GAP_CYC
) (
	// clock, reset and register port
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// connector and board setup
	input wire logic        ext_clk_in,
	input wire logic        clk_out_drive,
	input wire logic        res_8bit,
	input wire logic [3:0]  chan_per_module,
	// outputs
	input wire logic        sample_clk,
	input wire logic        sample_tick,
	input wire logic        sample_valid,
	input wire logic        term_en,
	input wire logic        band_fast_sel,
	input wire logic        divided_mode_on
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	function automatic logic [31:0] lim_f(input logic r8, input logic [3:0] c);
		case (c)
			4'h1: return `ECDR_LIM_50M0;
			4'h2: return r8 ? `ECDR_LIM_50M0 : `ECDR_LIM_25M0;
			4'h4: return r8 ? `ECDR_LIM_25M0 : `ECDR_LIM_12M5;
			4'h8: return r8 ? `ECDR_LIM_12M5 : `ECDR_LIM_6M0;
			default: return 32'h0;
		endcase
	endfunction : lim_f
	wire mode_wr = reg_wr && reg_addr == `ECDR_OFF_MODE;
	wire band_wr = reg_wr && reg_addr == `ECDR_OFF_BAND;
	AST_MODE_ON: assert property (mode_wr && reg_wdata == `ECDR_MODE_DIVIDED |-> ##[1:2] divided_mode_on) else $error("mode 16 not taken");
	AST_MODE_OFF: assert property (mode_wr && reg_wdata != `ECDR_MODE_DIVIDED |-> ##[1:2] !divided_mode_on) else $error("mode off not taken");
	AST_IDLE_QUIET: assert property (!divided_mode_on [*3] |-> !sample_tick && !sample_clk) else $error("sample clock outside divided mode");
	AST_TICK_EDGE: assert property (sample_tick |-> $past(ext_clk_in, 2) && !$past(ext_clk_in, 3)) else $error("tick not two cycles after edge");
	AST_TICK_RISE: assert property (sample_tick |-> $rose(sample_clk)) else $error("tick apart from divided rise");
	AST_VALID_TICK: assert property (sample_valid |-> sample_tick) else $error("valid without tick");
	AST_TERM: assert property (term_en |-> !$past(clk_out_drive)) else $error("termination on a driven connector");
	AST_BAND_FAST: assert property (band_wr && reg_wdata == 32'h80 |-> ##[1:2] band_fast_sel) else $error("fast band not taken");
	AST_BAND_SLOW: assert property (band_wr && reg_wdata == 32'h40 |-> ##[1:2] !band_fast_sel) else $error("slow band not taken");
	AST_BAND_KEEP: assert property (band_wr && reg_wdata != 32'h40 && reg_wdata != 32'h80 |=> $stable(band_fast_sel) [*2]) else $error("illegal band changed select");
	AST_LIMIT: assert property (reg_rd && reg_addr == `ECDR_OFF_LIMIT |=> reg_rdata == lim_f($past(res_8bit), $past(chan_per_module))) else $error("band limit wrong");
	COV_TICK: cover property (sample_tick && sample_valid);
	COV_GAP: cover property (sample_tick && !sample_valid);
	COV_FAST: cover property (band_fast_sel && sample_tick);
	COV_TERM: cover property (term_en);
endmodule : ecdr_top_checker
bind ecdr_top ecdr_top_checker #(.DIV_MAX(DIV_MAX), .GAP_CYC(GAP_CYC)) u_chk (.sys_clk, .nrst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_clk_in, .clk_out_drive, .res_8bit,
	.chan_per_module, .sample_clk, .sample_tick, .sample_valid, .term_en, .band_fast_sel,
	.divided_mode_on);
`default_nettype wire

// >>> bench/test_external_clock_divider_range.sv
// self-checking bench for the divided external clock block
`default_nettype none
`include "ecdr_regs.svh"
module test_external_clock_divider_range;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned GAP = 8;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [15:0] reg_addr = 16'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        drv = 1'b0;
	logic        r8 = 1'b0;
	logic        gen_on = 1'b0;
	logic [3:0]  chans = 4'h1;
	logic [31:0] reg_rdata;
	logic        ext_clk, s_clk, s_tick, s_valid, t_en, f_sel, m_on;
	int          err_total = 0;
	int          compares = 0;
	int          cyc = 0;
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	ecdr_top #(.GAP_CYC(GAP)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_clk_in(ext_clk), .clk_out_drive(drv), .res_8bit(r8), .chan_per_module(chans),
		.sample_clk(s_clk), .sample_tick(s_tick), .sample_valid(s_valid), .term_en(t_en),
		.band_fast_sel(f_sel), .divided_mode_on(m_on));
	ecdr_clk_gen u_gen (.sys_clk(sys_clk), .nrst(nrst), .run(gen_on), .half(4'h2),
		.ext_clk(ext_clk));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		rd(a, d);
		chk(nm, e, d);
	endtask : rchk
	// counts ticks and valid pulses after each edge has settled
	task automatic count(input int n, output int t, output int v);
		t = 0;
		v = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			t += int'(s_tick === 1'b1);
			v += int'(s_valid === 1'b1);
		end
	endtask : count
	task automatic t_regs();
		rchk(`ECDR_OFF_DIV, 32'h2, "div reset");
		rchk(`ECDR_OFF_BAND, 32'h40, "band reset");
		rchk(`ECDR_OFF_MODE, 32'h0, "mode reset");
		rchk(`ECDR_OFF_TERM, 32'h0, "term reset");
		wr(16'h0010, 32'hffffffff);
		rchk(16'h0010, 32'h0, "unmapped");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_div();
		logic [31:0] v[5] = '{32'd10, 32'd8190, 32'd7, 32'd0, 32'd8192};
		logic [31:0] e;
		for (int i = 0; i < 5; i++) begin
			wr(`ECDR_OFF_DIV, v[i]);
			if (i < 2) e = v[i];
			rchk(`ECDR_OFF_DIV, e, "divider");
			rchk(`ECDR_OFF_STAT, (i < 2) ? 32'h0 : 32'h4, "div reject flag");
			wr(`ECDR_OFF_STAT, 32'h3c);
		end
		$display("t_div done");
	endtask : t_div
	task automatic t_band();
		wr(`ECDR_OFF_BAND, 32'h80);
		rchk(`ECDR_OFF_BAND, 32'h80, "band fast");
		chk("fast select", 1'b1, f_sel);
		wr(`ECDR_OFF_BAND, 32'd100);
		rchk(`ECDR_OFF_BAND, 32'h80, "band kept");
		rchk(`ECDR_OFF_STAT, 32'h8, "band reject flag");
		wr(`ECDR_OFF_STAT, 32'h3c);
		wr(`ECDR_OFF_BAND, 32'h40);
		rchk(`ECDR_OFF_BAND, 32'h40, "band slow");
		chk("slow select", 1'b0, f_sel);
		$display("t_band done");
	endtask : t_band
	task automatic t_limit();
		logic [3:0] ch[4] = '{4'h1, 4'h2, 4'h4, 4'h8};
		int e8[4] = '{50000, 50000, 25000, 12500};
		int e16[4] = '{50000, 25000, 12500, 6000};
		for (int i = 0; i < 8; i++) begin
			r8 <= i[2];
			chans <= ch[i % 4];
			rchk(`ECDR_OFF_LIMIT, i[2] ? e8[i % 4] : e16[i % 4], "band limit");
		end
		chans <= 4'h3;
		rchk(`ECDR_OFF_LIMIT, 32'h0, "limit bad count");
		chans <= 4'h1;
		$display("t_limit done");
	endtask : t_limit
	task automatic t_term();
		logic [31:0] s;
		wr(`ECDR_OFF_TERM, 32'h1);
		repeat (3) @(posedge sys_clk);
		chk("term on", 1'b1, t_en);
		rd(`ECDR_OFF_STAT, s);
		chk("term status", 32'h40, s & 32'h40);
		drv <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("term driven", 1'b0, t_en);
		drv <= 1'b0;
		wr(`ECDR_OFF_TERM, 32'h0);
		repeat (3) @(posedge sys_clk);
		chk("term off", 1'b0, t_en);
		$display("t_term done");
	endtask : t_term
	task automatic t_run();
		int t, v;
		wr(`ECDR_OFF_MODE, `ECDR_MODE_DIVIDED);
		// 5 MHz in, divided clock far below every boundary: slow band
		wr(`ECDR_OFF_BAND, 32'h40);
		gen_on <= 1'b1;
		wr(`ECDR_OFF_CMD, 32'h1 << `ECDR_CMD_START);
		chk("mode on", 1'b1, m_on);
		for (int d = 2; d <= 6; d += 4) begin
			wr(`ECDR_OFF_DIV, d);
			repeat (30) @(posedge sys_clk);
			count(240, t, v);
			chk("tick rate", 1'b1, t + 1 >= 60 / d && t <= 60 / d + 1);
			chk("valid count", t, v);
		end
		wr(`ECDR_OFF_MODE, 32'h0);
		repeat (4) @(posedge sys_clk);
		count(40, t, v);
		chk("no ticks mode off", 0, t);
		$display("t_run done");
	endtask : t_run
	task automatic t_fast();
		int t, v;
		logic [31:0] s;
		gen_on <= 1'b0;
		repeat (GAP + 4) @(posedge sys_clk);
		wr(`ECDR_OFF_MODE, `ECDR_MODE_DIVIDED);
		wr(`ECDR_OFF_BAND, 32'h80);
		wr(`ECDR_OFF_STAT, 32'h3c);
		wr(`ECDR_OFF_CMD, 32'h1 << `ECDR_CMD_START);
		rd(`ECDR_OFF_STAT, s);
		chk("armed flags", 32'h10, s & 32'h11);
		count(20, t, v);
		chk("no ticks armed", 0, t);
		gen_on <= 1'b1;
		count(100, t, v);
		chk("ticks after clock", 1'b1, t > 0);
		rd(`ECDR_OFF_STAT, s);
		chk("running", 32'h1, s & 32'h1);
		wr(`ECDR_OFF_CMD, 32'h1 << `ECDR_CMD_STOP);
		$display("t_fast done");
	endtask : t_fast
	task automatic t_gap();
		int n;
		logic [31:0] s;
		wr(`ECDR_OFF_BAND, 32'h40);
		wr(`ECDR_OFF_DIV, 32'h2);
		wr(`ECDR_OFF_STAT, 32'h3c);
		wr(`ECDR_OFF_CMD, 32'h1 << `ECDR_CMD_START);
		repeat (40) @(posedge sys_clk);
		gen_on <= 1'b0;
		repeat (GAP + 6) @(posedge sys_clk);
		gen_on <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (s_tick !== 1'b1 && n < 80);
		chk("tick after gap", 1'b1, s_tick);
		chk("valid after gap", 1'b0, s_valid);
		rd(`ECDR_OFF_STAT, s);
		chk("gap flag", 32'h20, s & 32'h20);
		$display("t_gap done");
	endtask : t_gap
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		t_regs();
		t_div();
		t_band();
		t_limit();
		t_term();
		t_run();
		t_fast();
		t_gap();
		print_verdict();
	end
endmodule : test_external_clock_divider_range
`default_nettype wire
